// File: hw/adcsa_pkg.sv
// adcsa_pkg: constants and carrier types for the stand-alone converter control block.
// assumes a single 40 MHz system clock and an Avalon-MM register bus.
package adcsa_pkg;
  localparam int unsigned SYS_CLK_HZ  = 40_000_000;
  localparam int unsigned CONV_CLK_HZ = 2_000_000;
  localparam int unsigned CONV_DIV    = SYS_CLK_HZ / CONV_CLK_HZ;
  localparam logic [4:0]  CONV_DIV_LAST = 5'(CONV_DIV - 1);
  // first decision 1.5 conversion-clock periods after start (rounded up)
  localparam int unsigned FIRST_DEC_CYC = (3 * CONV_DIV + 1) / 2;
  localparam logic [5:0]  FIRST_DEC_LAST = 6'(FIRST_DEC_CYC - 1);
  localparam int unsigned RES_W       = 12;
  localparam logic [11:0] HALF_SCALE  = 12'h800;
  localparam logic [11:0] RES_RST     = 12'h000;
  localparam logic [3:0]  MSB_IDX     = 4'hb;
  // register word addresses
  localparam logic [1:0] ADDR_CTRL   = 2'h0;
  localparam logic [1:0] ADDR_STATUS = 2'h1;
  localparam logic [1:0] ADDR_IRQ    = 2'h2;
  localparam logic [1:0] ADDR_MASK   = 2'h3;
  // control, status and interrupt fields
  localparam int unsigned CTRL_BIPOLAR = 0;
  localparam int unsigned STAT_BUSY    = 0;
  localparam int unsigned IRQ_W        = 2;
  localparam int unsigned IRQ_DONE     = 0;
  localparam int unsigned IRQ_IGNORED  = 1;
  localparam logic [31:0] BAD_ADDR_DATA = 32'hdeadbeef;

  typedef enum logic [1:0] {ST_IDLE, ST_SETTLE, ST_BIT} adcsa_state_t;

  typedef struct packed {
    logic [1:0]  address;
    logic        read;
    logic        write;
    logic [31:0] writedata;
  } adcsa_bus_req_t;

  typedef struct packed {
    adcsa_state_t      state;
    logic              rc_q;
    logic              bipolar;
    logic              busy;
    logic              drive;
    logic [11:0]       approximation_register;
    logic [11:0]       result;
    logic [3:0]        bit_idx;
    logic [5:0]        tick;
    logic [IRQ_W-1:0]  irq_stat;
    logic [IRQ_W-1:0]  irq_mask;
    logic              irq;
    logic              waitreq;
    logic [31:0]       rdata;
  } adcsa_regs_t;
endpackage : adcsa_pkg

// File: hw/adcsa_top.sv
// adcsa_top: stand-alone control of a 12-bit successive-approximation converter.
// one read/convert line starts conversions and gates the result outputs; a
// busy flag covers each conversion; a small register bus gives software the
// coding bit (stored and read back only; it does not change the result coding), the busy level and sticky interrupt bits.
// assumes the read/convert input and comparator are synchronous to i_sys_clk.
// assumes the comparator settles within one system clock of a new trial code.
//
// Local design decisions: the register addresses and the Avalon-MM slave port.
`timescale 1ns/10ps
`default_nettype none
module adcsa_top
  import adcsa_pkg::*;
(
  input  wire logic              i_sys_clk,      // system clock, 40 MHz
  input  wire logic              i_resetn,       // async reset, active low
  input  wire logic              i_rd_conv,      // read/convert control line
  input  wire logic              i_cmp_above,    // comparator: input above trial
  input  wire logic [1:0]        i_avs_address,  // word address
  input  wire logic              i_avs_read,     // bus read
  input  wire logic              i_avs_write,    // bus write
  input  wire logic [31:0]       i_avs_writedata,// bus write data
  output logic [31:0]            o_avs_readdata, // bus read data
  output logic                   o_avs_waitrequest, // bus stall
  output logic [11:0]            o_dac_code,     // trial code to internal dac
  output logic [11:0]            o_data,         // result data out
  output logic                   o_data_oe,      // data output enable
  output logic                   o_busy_flag,    // conversion in progress
  output logic                   o_irq           // level interrupt
);
  import adcsa_pkg::*;

  // whole block state, registered once per clock
  adcsa_regs_t    r_ff, nxt_r;
  adcsa_bus_req_t req;
  // falling edge of the line, decoded in the first cycle the line is low
  logic           start_req;
  // first cycle of a bus read or write: read data is loaded here on a read
  logic           acc;
  // second cycle of a write: the write lands here
  logic           wr_acc;

  assign req = '{address: i_avs_address, read: i_avs_read, write: i_avs_write,
                 writedata: i_avs_writedata};

  // ----------------------------------------------------------------
  // conversion and bus next state
  // ----------------------------------------------------------------
  // everything starts from the held state; each branch below only
  // touches the fields it owns, so an idle cycle changes nothing but
  // the edge detector, the output enable, the bus handshake and the read data register.
  always_comb begin
    nxt_r = r_ff;
    nxt_r.rc_q = i_rd_conv;
    start_req = r_ff.rc_q & ~i_rd_conv;
    // the output enable is a level: it is set while idle with the line high and at the end
    // of a conversion with the line low, and is forced low by any falling edge except one in the
    // cycle that decides the lsb, so even a short low pulse floats it.
    // drive while line high
    if (i_rd_conv && r_ff.state == ST_IDLE) begin
      nxt_r.drive = 1'b1;
    end
    if (start_req) begin
      nxt_r.drive = 1'b0;
    end
    case (r_ff.state)
      ST_IDLE: begin
        if (start_req) begin
          nxt_r.approximation_register     = HALF_SCALE;
          nxt_r.bit_idx = MSB_IDX;
          nxt_r.tick    = '0;
          nxt_r.busy    = 1'b1;
          nxt_r.state   = ST_SETTLE;
        end
      end
      ST_SETTLE: begin
        // the trial code stays at half scale here so the external hold has
        // time to settle before the msb is judged.
        // first decision at 1.5 periods
        if (r_ff.tick == FIRST_DEC_LAST) begin
          nxt_r.tick  = '0;
          nxt_r.state = ST_BIT;
          nxt_r.approximation_register[r_ff.bit_idx] = i_cmp_above;
          if (r_ff.bit_idx != '0) begin
            nxt_r.approximation_register[r_ff.bit_idx - 4'h1] = 1'b1;
          end
          nxt_r.bit_idx = r_ff.bit_idx - 4'h1;
        end else begin
          nxt_r.tick = r_ff.tick + 6'h1;
        end
      end
      ST_BIT: begin
        // tick counts system clocks within one divided period; the comparator
        // is read on the last one, after the new trial code has settled.
        // one decision per 2 MHz period
        if (r_ff.tick[4:0] == CONV_DIV_LAST) begin
          nxt_r.tick = '0;
          nxt_r.approximation_register[r_ff.bit_idx] = i_cmp_above;
          if (r_ff.bit_idx == '0) begin
            nxt_r.result = {nxt_r.approximation_register[11] ^ 1'b0, nxt_r.approximation_register[10:0]};
            nxt_r.busy   = 1'b0;
            nxt_r.state  = ST_IDLE;
            nxt_r.irq_stat[IRQ_DONE] = 1'b1;
            // drive again if line already low
            if (!i_rd_conv && !r_ff.drive) begin
              nxt_r.drive = 1'b1;
            end
          end else begin
            nxt_r.approximation_register[r_ff.bit_idx - 4'h1] = 1'b1;
            nxt_r.bit_idx = r_ff.bit_idx - 4'h1;
          end
        end else begin
          nxt_r.tick = r_ff.tick + 6'h1;
        end
      end
      default: nxt_r.state = ST_IDLE;
    endcase
    if (start_req && r_ff.busy) begin
      nxt_r.irq_stat[IRQ_IGNORED] = 1'b1;
    end
    // bus slave: one wait state, answer on the second cycle. the first
    // cycle loads the read data register so that it stands at the edge
    // where waitrequest is seen low; a write lands only on that edge, so
    // a request dropped while stalled leaves no trace.
    acc           = (req.read | req.write) & r_ff.waitreq;
    wr_acc        = req.write & ~r_ff.waitreq;
    nxt_r.waitreq = ~(req.read | req.write) | ~r_ff.waitreq;
    if (wr_acc) begin
      case (req.address)
        ADDR_CTRL:   nxt_r.bipolar = req.writedata[CTRL_BIPOLAR];
        // write one clears, a new event in the same cycle wins unless its bit was already set
        ADDR_IRQ:    nxt_r.irq_stat = nxt_r.irq_stat &
                       ~(req.writedata[IRQ_W-1:0] & ~(nxt_r.irq_stat & ~r_ff.irq_stat));
        ADDR_MASK:   nxt_r.irq_mask = req.writedata[IRQ_W-1:0];
        default:     ;
      endcase
    end
    nxt_r.rdata = '0;
    if (acc && req.read) begin
      case (req.address)
        ADDR_CTRL:   nxt_r.rdata[CTRL_BIPOLAR] = r_ff.bipolar;
        ADDR_STATUS: nxt_r.rdata[STAT_BUSY]    = r_ff.busy;
        ADDR_IRQ:    nxt_r.rdata[IRQ_W-1:0]    = r_ff.irq_stat;
        ADDR_MASK:   nxt_r.rdata[IRQ_W-1:0]    = r_ff.irq_mask;
        default:     nxt_r.rdata = BAD_ADDR_DATA;
      endcase
    end
    nxt_r.irq = |(nxt_r.irq_stat & nxt_r.irq_mask);
  end

  // ----------------------------------------------------------------
  // state register
  // ----------------------------------------------------------------
  // reset values are constants only; waitrequest resets high so a master
  // that starts right after reset is stalled, never answered by mistake.
  always_ff @(posedge i_sys_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      r_ff         <= '0;
      r_ff.state   <= ST_IDLE;
      r_ff.result  <= RES_RST;
      r_ff.waitreq <= 1'b1;
    end else begin
      r_ff <= nxt_r;
    end
  end

  // every output is a plain register field, so the pins never glitch
  // while the next state is being worked out.
  // hold last result on the pins
  assign o_data            = r_ff.result;
  assign o_data_oe         = r_ff.drive;
  assign o_busy_flag       = r_ff.busy;
  assign o_dac_code        = r_ff.approximation_register;
  assign o_irq             = r_ff.irq;
  assign o_avs_readdata    = r_ff.rdata;
  assign o_avs_waitrequest = r_ff.waitreq;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  // the conversion timeline seen from the busy flag: busy is first
  // sampled high one edge after the start edge, the first decision
  // lands one and a half divided periods after start, every further
  // bit takes one divided period, and busy drops on the edge that
  // decides the lsb. the gaps below are counted from the edge where
  // busy is first seen high, so they are one short of the full span.
  // a restart would put the state back to settle with a zero tick.
  localparam int CHK_FIRST_GAP = FIRST_DEC_CYC - 1;
  localparam int CHK_CONV_GAP  = FIRST_DEC_CYC + (RES_W - 1) * CONV_DIV - 1;

  property p_busy_rise;
    @(posedge i_sys_clk) disable iff (!i_resetn)
      ($fell(i_rd_conv) && r_ff.state == ST_IDLE) |=> o_busy_flag;
  endproperty
  a_busy_rise: assert property (p_busy_rise) else $error("busy not raised");

  property p_float;
    @(posedge i_sys_clk) disable iff (!i_resetn)
      $fell(i_rd_conv) |=> !o_data_oe;
  endproperty
  a_float: assert property (p_float) else $error("data not floated");

  property p_ignore;
    @(posedge i_sys_clk) disable iff (!i_resetn)
      (o_busy_flag && $fell(i_rd_conv)) |=> !(r_ff.state == ST_SETTLE && r_ff.tick == '0);
  endproperty
  a_ignore: assert property (p_ignore) else $error("start not ignored");

  property p_half;
    @(posedge i_sys_clk) disable iff (!i_resetn)
      $rose(o_busy_flag) |-> o_dac_code == HALF_SCALE;
  endproperty
  a_half: assert property (p_half) else $error("not half scale");

  property p_first;
    @(posedge i_sys_clk) disable iff (!i_resetn)
      $rose(o_busy_flag) |-> (r_ff.state == ST_SETTLE) [*8];
  endproperty
  a_first: assert property (p_first) else $error("first decision early");

  property p_drive_hi;
    @(posedge i_sys_clk) disable iff (!i_resetn)
      (i_rd_conv && !o_busy_flag) |=> o_data_oe;
  endproperty
  a_drive_hi: assert property (p_drive_hi) else $error("not driving");

  property p_done;
    @(posedge i_sys_clk) disable iff (!i_resetn)
      $rose(o_busy_flag) |-> ##CHK_CONV_GAP o_busy_flag ##1 !o_busy_flag;
  endproperty
  a_done: assert property (p_done) else $error("conversion length");

  property p_hold;
    @(posedge i_sys_clk) disable iff (!i_resetn)
      (o_busy_flag ##1 o_busy_flag) |-> $stable(o_data);
  endproperty
  a_hold: assert property (p_hold) else $error("result changed");

  property p_first_dec;
    @(posedge i_sys_clk) disable iff (!i_resetn)
      $rose(o_busy_flag) |-> ##CHK_FIRST_GAP (r_ff.state == ST_SETTLE) ##1 (r_ff.state == ST_BIT);
  endproperty
  a_first_dec: assert property (p_first_dec) else $error("first decision late");

  property p_oe_busy;
    @(posedge i_sys_clk) disable iff (!i_resetn)
      o_busy_flag |-> !o_data_oe;
  endproperty
  a_oe_busy: assert property (p_oe_busy) else $error("driven while busy");

  property p_latch;
    @(posedge i_sys_clk) disable iff (!i_resetn)
      $fell(o_busy_flag) |-> (o_data[11:1] == $past(o_dac_code[11:1]));
  endproperty
  a_latch: assert property (p_latch) else $error("result not latched");

  property p_ignore_flag;
    @(posedge i_sys_clk) disable iff (!i_resetn)
      (o_busy_flag && $fell(i_rd_conv)) |=> r_ff.irq_stat[IRQ_IGNORED];
  endproperty
  a_ignore_flag: assert property (p_ignore_flag) else $error("ignored start not flagged");

  property p_done_flag;
    @(posedge i_sys_clk) disable iff (!i_resetn)
      $fell(o_busy_flag) |-> r_ff.irq_stat[IRQ_DONE];
  endproperty
  a_done_flag: assert property (p_done_flag) else $error("done not flagged");

  property p_start_idle;
    @(posedge i_sys_clk) disable iff (!i_resetn)
      (!o_busy_flag && $fell(i_rd_conv)) |=> (r_ff.state == ST_SETTLE && o_dac_code == HALF_SCALE);
  endproperty
  a_start_idle: assert property (p_start_idle) else $error("start not taken");

  property p_tick_range;
    @(posedge i_sys_clk) disable iff (!i_resetn)
      (r_ff.state == ST_BIT) |-> (r_ff.tick < CONV_DIV);
  endproperty
  a_tick_range: assert property (p_tick_range) else $error("tick out of range");

  property p_stat_sticky;
    @(posedge i_sys_clk) disable iff (!i_resetn)
      (r_ff.irq_stat[IRQ_DONE] && !i_avs_write) |=> r_ff.irq_stat[IRQ_DONE];
  endproperty
  a_stat_sticky: assert property (p_stat_sticky) else $error("status bit lost");

  // bus: one cycle answer
  property p_wait_once;
    @(posedge i_sys_clk) disable iff (!i_resetn)
      !o_avs_waitrequest |=> o_avs_waitrequest;
  endproperty
  a_wait_once: assert property (p_wait_once) else $error("waitrequest low too long");

  // bus: stall when idle
  property p_wait_idle;
    @(posedge i_sys_clk) disable iff (!i_resetn)
      !(i_avs_read || i_avs_write) |=> o_avs_waitrequest;
  endproperty
  a_wait_idle: assert property (p_wait_idle) else $error("answer without request");

  // bus: answer next cycle
  property p_wait_ack;
    @(posedge i_sys_clk) disable iff (!i_resetn)
      ((i_avs_read || i_avs_write) && o_avs_waitrequest) |=> !o_avs_waitrequest;
  endproperty
  a_wait_ack: assert property (p_wait_ack) else $error("request not answered");
endmodule : adcsa_top
`default_nettype wire

// File: tb/adcsa_host_model.sv
// adcsa_host_model: host-side track-and-hold and comparator in front of the converter.
// assumes the bench sets the analog level and the block's trial code is registered.
`timescale 1ns/10ps
`default_nettype none
module adcsa_host_model (
  input  wire logic        i_sys_clk,  // system clock
  input  wire logic        i_hold,     // hold command, taken from the busy flag
  input  wire logic [11:0] i_vin,      // analog level in lsb units
  input  wire logic [11:0] i_dac_code, // trial code from the block
  output logic             o_cmp_above // input at or above trial
);
  logic [11:0] held_ff;
  // busy as hold
  // tracks while idle, so the level is frozen for the whole conversion
  always_ff @(posedge i_sys_clk) begin
    if (!i_hold) held_ff <= i_vin;
  end
  assign o_cmp_above = (held_ff >= i_dac_code);
endmodule : adcsa_host_model
`default_nettype wire

// File: tb/tb.sv
// tb: self-checking bench for the stand-alone converter control block.
// assumes adcsa_pkg, the design and the host model are compiled first.
`timescale 1ns/10ps
`default_nettype none
module tb;
  import adcsa_pkg::*;
  logic        clk = 1'b0, rstn = 1'b0, rc = 1'b1, rd = 1'b0, wr = 1'b0;
  logic        cmp, wreq, oe, busy, irq;
  logic [1:0]  adr = 2'h0;
  logic [31:0] wd = 32'h0, rdat, q;
  logic [11:0] dac, dat, vin = 12'h000;
  int          err_count = 0, num_checks = 0, cyc = 0;
  always #12.5 clk = ~clk;
  adcsa_top dut (.i_sys_clk(clk), .i_resetn(rstn), .i_rd_conv(rc), .i_cmp_above(cmp),
    .i_avs_address(adr), .i_avs_read(rd), .i_avs_write(wr), .i_avs_writedata(wd),
    .o_avs_readdata(rdat), .o_avs_waitrequest(wreq), .o_dac_code(dac), .o_data(dat),
    .o_data_oe(oe), .o_busy_flag(busy), .o_irq(irq));
  adcsa_host_model host (.i_sys_clk(clk), .i_hold(busy), .i_vin(vin), .i_dac_code(dac),
    .o_cmp_above(cmp));
  // ---------------------------------------------------------------
  // shared tasks
  // ---------------------------------------------------------------
  task chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      err_count++;
      $display("wrong value at %0t: got %h want %h", $time, got, exp);
    end
  endtask : chk
  // one avalon transfer, held until waitrequest is seen low
  task bus(input logic w, input logic [1:0] a, input logic [31:0] d);
    @(posedge clk);
    adr <= a;
    rd <= !w;
    wr <= w;
    wd <= d;
    do @(posedge clk); while (wreq !== 1'b0);
    q = rdat;
    rd <= 1'b0;
    wr <= 1'b0;
  endtask : bus
  task wrap_up;
    $display("checks %0d errors %0d", num_checks, err_count);
    if (err_count == 0 && num_checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : wrap_up
  // hang guard: full run needs well under 2000 cycles
  always @(posedge clk) begin
    cyc++;
    if (cyc == 6000) begin
      err_count++;
      wrap_up;
    end
  end
  // ---------------------------------------------------------------
  // scenarios
  // ---------------------------------------------------------------
  // one conversion; glitch re-pulses the line while busy
  task t_conv(input logic [11:0] v, input logic glitch);
    int n, nb;
    logic [11:0] last;
    bus(1'b1, ADDR_IRQ, 32'h3);
    @(posedge clk);
    vin <= v;
    rc <= 1'b0;
    n = 0;
    do begin @(posedge clk); n++; end while (busy !== 1'b1 && n < 4);
    rc <= 1'b1;
    chk(busy, 1'b1);
    chk(oe, 1'b0);
    chk(dac, HALF_SCALE);
    n = 0;
    do begin @(posedge clk); n++; end while (dac === HALF_SCALE && n < 60);
    chk(32'(n >= 29 && n <= 32), 1);
    last = dac;
    nb = n;
    n = 0;
    do begin @(posedge clk); n++; end while (dac === last && n < 60);
    chk(n, CONV_DIV);
    if (glitch) begin
      rc <= 1'b0;
      @(posedge clk);
      rc <= 1'b1;
    end
    do begin @(posedge clk); n++; end while (busy !== 1'b0 && n < 400);
    nb = nb + n;
    chk(32'(nb >= 245 && nb <= 256), 1);
    @(posedge clk);
    chk(dat, v);
    chk(oe, 1'b1);
    bus(1'b0, ADDR_IRQ, 32'h0);
    chk(q, {30'h0, glitch, 1'b1});
  endtask : t_conv
  // mask changes the level output; write one clears
  task t_irq;
    bus(1'b1, ADDR_MASK, 32'h0);
    @(posedge clk);
    chk(irq, 1'b0);
    bus(1'b1, ADDR_MASK, 32'h3);
    @(posedge clk);
    chk(irq, 1'b1);
    bus(1'b1, ADDR_IRQ, 32'h1);
    bus(1'b0, ADDR_IRQ, 32'h0);
    chk(q, 32'h0);
    chk(irq, 1'b0);
    chk(dat, 12'h7ff);
  endtask : t_irq
  initial begin
    @(negedge clk);
    chk(wreq, 1'b1);
    chk(oe, 1'b0);
    repeat (2) @(posedge clk);
    rstn <= 1'b1;
    bus(1'b0, ADDR_MASK, 32'h0);
    chk(q, 32'h0);
    bus(1'b0, ADDR_STATUS, 32'h0);
    chk(q, 32'h0);
    t_conv(12'hfff, 1'b0);
    t_conv(12'h000, 1'b1);
    bus(1'b1, ADDR_CTRL, 32'h1);
    bus(1'b0, ADDR_CTRL, 32'h0);
    chk(q, 32'h1);
    t_conv(12'h800, 1'b0);
    t_conv(12'h7ff, 1'b0);
    t_irq;
    wrap_up;
  end
endmodule : tb
`default_nettype wire
